/* src/timer_waveform_pkg.sv */
// Constants, register map and state types of the 8-bit timer waveform block.
//==========================================================================
// What this block does
// [RQ1] Reset clears the internal compare output state.
// [RQ2] Nonzero output mode puts state on pin.
// [RQ3] Pin shows state only when direction selects output.
// [RQ4] Pin override ignores the waveform mode.
// [RQ5] Output mode zero leaves state untouched.
// [RQ6] New output mode acts at next match; force acts now in non-PWM modes.
// [RQ7] Only waveform mode bits choose counting.
// [RQ8] Normal mode increments, never clears, wraps.
// [RQ9] Normal mode sets overflow as count becomes zero.
// [RQ10] Normal mode accepts count writes anytime.
// [RQ11] Clear-on-match mode clears count at compare value.
// [RQ12] Compare written directly; low value waits for wrap.
// [RQ13] Clear-on-match with mode one toggles state.
// [RQ14] Clear-on-match sets match flag and overflow.
// [RQ15] Fast PWM counts zero to maximum, then clears.
// [RQ16] Fast PWM: mode two clear/set, three set/clear.
// [RQ17] Fast PWM sets overflow at maximum.
// [RQ18] Fast PWM extremes give spike or constant level.
// [RQ19] Software can preset state before enabling output.
// [RQ20] Maximum is all ones, bottom is zero.
// [RQ21] Compare buffered in PWM, direct otherwise.
// [RQ22] Match sets flag on next timer tick.
// [RQ23] Count write blocks matches for one tick.
// [RQ24] Counting and match events on clock, qualified by tick.
package timer_waveform_pkg;

    //======================================================================
    // Register offsets, byte addresses on the APB.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_COMPARE = 12'h008;
    localparam logic [11:0] OFS_FLAGS = 12'h00C;
    localparam logic [11:0] OFS_OUTSTATE = 12'h010;

    //======================================================================
    // Control register field positions.
    localparam int POS_FORCE = 7;
    localparam int POS_COM_LO = 4;
    localparam int POS_WGM_LO = 0;
    // Flag register field positions.
    localparam int POS_OVF = 0;
    localparam int POS_CMF = 1;

    //======================================================================
    // Waveform modes, output modes and count extremes.
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE = 2'h1;
    localparam logic [1:0] WGM_CLEAR = 2'h2;
    localparam logic [1:0] WGM_FAST = 2'h3;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    //======================================================================
    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    //======================================================================
    // State carriers.
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] cmp_buf;
        logic [7:0] cmp_act;
        logic [1:0] wgm;
        logic [1:0] com;
        logic oc;
        logic block;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pin_o;
        logic pin_oe;
    } timer_state_t;

    typedef struct packed {
        logic flag;
    } flag_state_t;

endpackage : timer_waveform_pkg

/* src/sticky_flag.sv */
// Sticky event flag, set by hardware and cleared by software.
`timescale 1ns/10ps

module sticky_flag (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic set,
    input wire logic clr,
    output logic flag
);

    timer_waveform_pkg::flag_state_t s_r;
    timer_waveform_pkg::flag_state_t s_nxt;

    //======================================================================
    // Next state: a set in the same cycle as a clear wins, so no event is lost.
    always_comb begin
        s_nxt = s_r;
        if (clr) begin
            s_nxt.flag = 1'b0;
        end
        if (set) begin
            s_nxt.flag = 1'b1;
        end
    end

    // Register; the clock enable freezes the flag.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign flag = s_r.flag;

endmodule : sticky_flag

/* src/timer_waveform_modes_8bit.sv */
// Counter, compare, waveform output and APB registers of the 8-bit timer.
`timescale 1ns/10ps

module timer_waveform_modes_8bit (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic timer_tick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_data_bit,
    input wire logic pin_direction_bit,
    output logic pin_o,
    output logic pin_oe,
    output logic overflow_flag,
    output logic compare_match_flag
);

    timer_waveform_pkg::timer_state_t s_r;
    timer_waveform_pkg::timer_state_t s_nxt;

    //======================================================================
    // Decode and event signals shared by the next-state logic.
    logic access;
    logic wr;
    logic wr_ctrl;
    logic wr_count;
    logic wr_compare;
    logic wr_flags;
    logic tick;
    logic pwm;
    logic match;
    logic at_max;
    logic ovf_set;
    logic ovf_clr;
    logic cmf_clr;
    logic ovf_q;
    logic cmf_q;
    logic [1:0] wr_com;
    logic [1:0] wr_wgm;
    logic wr_force;

    //======================================================================
    // Action of a non-PWM compare match (or a forced one) on the output state.
    function automatic logic match_action(input logic [1:0] com, input logic oc);
        logic r;
        r = oc;
        case (com)
            timer_waveform_pkg::COM_TOGGLE: begin
                r = ~oc;
            end
            timer_waveform_pkg::COM_CLEAR: begin
                r = 1'b0;
            end
            timer_waveform_pkg::COM_SET: begin
                r = 1'b1;
            end
            default: begin
                r = oc; // Output mode zero performs no action.
            end
        endcase
        return r;
    endfunction : match_action

    //======================================================================
    // APB access phase: one wait state, so the write takes effect and the
    // read data is taken at the edge where pready is already high.
    assign access = psel && penable && s_r.pready;
    assign wr = access && pwrite;
    assign wr_ctrl = wr && (paddr == timer_waveform_pkg::OFS_CTRL);
    assign wr_count = wr && (paddr == timer_waveform_pkg::OFS_COUNT);
    assign wr_compare = wr && (paddr == timer_waveform_pkg::OFS_COMPARE);
    assign wr_flags = wr && (paddr == timer_waveform_pkg::OFS_FLAGS);

    // Fields of a control write.
    assign wr_com = pwdata[timer_waveform_pkg::POS_COM_LO +: 2];
    assign wr_wgm = pwdata[timer_waveform_pkg::POS_WGM_LO +: 2];
    assign wr_force = pwdata[timer_waveform_pkg::POS_FORCE];

    //======================================================================
    // Timer events. The tick comes from a prescaler on this same clock.
    assign tick = timer_tick; // RQ24
    assign pwm = s_r.wgm[0];
    assign at_max = tick && (s_r.count == timer_waveform_pkg::COUNT_MAX); // RQ20
    // A match is suppressed during the tick that follows a count write.
    assign match = tick && (s_r.count == s_r.cmp_act) && !s_r.block; // RQ23

    // Overflow is set in the tick that leaves maximum for zero. The dual
    // slope mode is not built here and sets no overflow.
    assign ovf_set = at_max && (s_r.wgm != timer_waveform_pkg::WGM_PHASE); // RQ9 RQ14 RQ17

    // Software clears a flag by writing a one to it.
    assign ovf_clr = wr_flags && pwdata[timer_waveform_pkg::POS_OVF];
    assign cmf_clr = wr_flags && pwdata[timer_waveform_pkg::POS_CMF];

    //======================================================================
    // Sticky status flags.
    sticky_flag u_ovf (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .set(ovf_set),
        .clr(ovf_clr),
        .flag(ovf_q)
    );

    // The match flag is set by the tick that sees equality.
    sticky_flag u_cmf (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .set(match), // RQ22 RQ14
        .clr(cmf_clr),
        .flag(cmf_q)
    );

    //======================================================================
    // Next state of counter, compare, output state and bus answer.
    always_comb begin
        s_nxt = s_r;

        // Counting depends on the waveform mode bits alone.
        if (tick) begin
            s_nxt.block = 1'b0;
            if ((s_r.wgm == timer_waveform_pkg::WGM_CLEAR) && match) begin
                s_nxt.count = timer_waveform_pkg::COUNT_BOTTOM; // RQ11 RQ7
            end else begin
                // Normal and fast PWM run up and wrap from maximum to zero.
                s_nxt.count = s_r.count + 8'h01; // RQ8 RQ15 RQ12
            end
        end

        // A count write overrides counting at any time and blocks a match.
        if (wr_count) begin
            s_nxt.count = pwdata[7:0]; // RQ10
            s_nxt.block = 1'b1; // RQ23
        end

        // In PWM modes the buffered compare value loads at the wrap.
        if (pwm && at_max) begin
            s_nxt.cmp_act = s_r.cmp_buf; // RQ21
        end
        if (wr_compare) begin
            s_nxt.cmp_buf = pwdata[7:0];
            if (!pwm) begin
                s_nxt.cmp_act = pwdata[7:0]; // RQ21 RQ12
            end
        end

        // Non-PWM modes set, clear or toggle at a match.
        if (!pwm && match) begin
            s_nxt.oc = match_action(s_r.com, s_r.oc); // RQ5 RQ13 RQ6
        end

        // Fast PWM: the wrap action comes last, so a compare value at
        // maximum gives a constant level and zero gives a one-tick spike.
        if (s_r.wgm == timer_waveform_pkg::WGM_FAST) begin
            if (match) begin
                if (s_r.com == timer_waveform_pkg::COM_CLEAR) begin
                    s_nxt.oc = 1'b0; // RQ16
                end else if (s_r.com == timer_waveform_pkg::COM_SET) begin
                    s_nxt.oc = 1'b1; // RQ16
                end
            end
            if (at_max) begin
                if (s_r.com == timer_waveform_pkg::COM_CLEAR) begin
                    s_nxt.oc = 1'b1; // RQ16 RQ18
                end else if (s_r.com == timer_waveform_pkg::COM_SET) begin
                    s_nxt.oc = 1'b0; // RQ16 RQ18
                end
            end
        end

        // Control write. The strobe acts at once in non-PWM modes, using the
        // output mode being written, and touches neither flag nor counter.
        if (wr_ctrl) begin
            s_nxt.com = wr_com; // RQ6
            s_nxt.wgm = wr_wgm;
            if (wr_force && !wr_wgm[0]) begin
                s_nxt.oc = match_action(wr_com, s_nxt.oc); // RQ6 RQ19
            end
        end

        // Pin mux: the override follows the output mode only, never the
        // waveform mode; the driver follows the direction bit.
        if (s_nxt.com != timer_waveform_pkg::COM_OFF) begin
            s_nxt.pin_o = s_nxt.oc; // RQ2 RQ4
        end else begin
            s_nxt.pin_o = port_data_bit;
        end
        s_nxt.pin_oe = pin_direction_bit; // RQ3

        // Bus answer, raised one cycle into the access phase.
        s_nxt.pready = psel && penable && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = timer_waveform_pkg::RST_WORD;
        if (s_nxt.pready) begin
            if (paddr == timer_waveform_pkg::OFS_CTRL) begin
                // The force strobe always reads as zero.
                s_nxt.prdata[timer_waveform_pkg::POS_COM_LO +: 2] = s_r.com;
                s_nxt.prdata[timer_waveform_pkg::POS_WGM_LO +: 2] = s_r.wgm;
            end else if (paddr == timer_waveform_pkg::OFS_COUNT) begin
                s_nxt.prdata[7:0] = s_r.count;
            end else if (paddr == timer_waveform_pkg::OFS_COMPARE) begin
                s_nxt.prdata[7:0] = s_r.cmp_buf;
            end else if (paddr == timer_waveform_pkg::OFS_FLAGS) begin
                s_nxt.prdata[timer_waveform_pkg::POS_OVF] = ovf_q;
                s_nxt.prdata[timer_waveform_pkg::POS_CMF] = cmf_q;
            end else if (paddr == timer_waveform_pkg::OFS_OUTSTATE) begin
                s_nxt.prdata[0] = s_r.oc;
            end else begin
                // Unmapped offsets answer with an error and zero data.
                s_nxt.pslverr = 1'b1;
            end
        end
    end

    //======================================================================
    // State register. Reset zeroes the output state like everything else;
    // the clock enable freezes all of it, bus answer included.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0; // RQ1
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    //======================================================================
    // Outputs, each straight from a flip-flop.
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign pin_o = s_r.pin_o;
    assign pin_oe = s_r.pin_oe;
    assign overflow_flag = ovf_q;
    assign compare_match_flag = cmf_q;

endmodule : timer_waveform_modes_8bit

/* tb/timer_waveform_props.sv */
// Port-level assertions for the 8-bit timer waveform block.
`timescale 1ns/10ps
module timer_waveform_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic timer_tick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pin_direction_bit,
    input wire logic pin_oe,
    input wire logic overflow_flag,
    input wire logic compare_match_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    //======================================================================
    // Helpers
    // A completed write to the flag register; only this may clear a flag.
    logic flag_wr;
    assign flag_wr = psel && penable && pready && pwrite && paddr == timer_waveform_pkg::OFS_FLAGS;
    sequence access_wait;
        psel && penable && !pready && ce;
    endsequence
    sequence answer_pulse;
        pready ##1 !pready;
    endsequence
    //======================================================================
    // Assertions
    // The direction reaches the pin one cycle late; reset edges are skipped.
    oe_follow_a: assert property ($past(rstn) && $past(rstn, 2) && $past(ce) |->
        pin_oe == $past(pin_direction_bit)) else $error("pin enable off direction");
    ready_wait_a: assert property (access_wait |=> answer_pulse)
        else $error("apb answer late or long");
    err_ready_a: assert property (pslverr |-> pready) else $error("slverr without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    ovf_hold_a: assert property (overflow_flag && !(flag_wr && pwdata[0]) |=> overflow_flag)
        else $error("overflow lost without clear");
    cmf_hold_a: assert property (compare_match_flag && !(flag_wr && pwdata[1]) |=>
        compare_match_flag) else $error("match flag lost without clear");
    ovf_tick_a: assert property ($rose(overflow_flag) |->
        $past(timer_tick) || $past(timer_tick, 2)) else $error("overflow without tick");
    cmf_tick_a: assert property ($rose(compare_match_flag) |->
        $past(timer_tick) || $past(timer_tick, 2)) else $error("match flag without tick");
    ovf_clear_a: assert property (flag_wr && pwdata[0] && !timer_tick && !$past(timer_tick)
        |=> !overflow_flag) else $error("overflow not cleared");
endmodule : timer_waveform_props

bind timer_waveform_modes_8bit timer_waveform_props i_props (.clk(clk), .rstn(rstn), .ce(ce),
    .timer_tick(timer_tick), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_direction_bit(pin_direction_bit), .pin_oe(pin_oe), .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag));

/* tb/gpio_pin_model.sv */
// Model of the general-purpose port pin that the timer output overrides.
`timescale 1ns/10ps
module gpio_pin_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sw_data,
    input wire logic sw_dir,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic port_data_bit,
    output logic pin_direction_bit,
    output logic pin_level
);
    //======================================================================
    // Port data and direction registers, written by software, cleared by reset.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port_data_bit <= 1'b0;
            pin_direction_bit <= 1'b0;
        end else begin
            port_data_bit <= sw_data;
            pin_direction_bit <= sw_dir;
        end
    end
    // The pad has a pull-up, so an undriven pin never shows the timer level.
    assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule : gpio_pin_model

/* tb/tb_top.sv */
// Self-checking bench for the 8-bit timer waveform block and its port pin.
`timescale 1ns/10ps
module tb_top;
    logic clk, rstn, ce, timer_tick, psel, penable, pwrite, pready, pslverr, d;
    logic port_data_bit, pin_direction_bit, pin_o, pin_oe, overflow_flag, compare_match_flag;
    logic sw_data, sw_dir, pin_level;
    logic [11:0] paddr;
    logic [7:0] cv;
    logic [31:0] pwdata, prdata;
    logic [32:0] exp_q[$];
    int error_cnt = 0;
    int num_checks = 0;
    // Addresses: control, count, compare, flags, output state.
    localparam logic [11:0] A [5] = '{timer_waveform_pkg::OFS_CTRL,
        timer_waveform_pkg::OFS_COUNT, timer_waveform_pkg::OFS_COMPARE,
        timer_waveform_pkg::OFS_FLAGS, timer_waveform_pkg::OFS_OUTSTATE};

    timer_waveform_modes_8bit i_dut (.clk(clk), .rstn(rstn), .ce(ce), .timer_tick(timer_tick),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_data_bit(port_data_bit),
        .pin_direction_bit(pin_direction_bit), .pin_o(pin_o), .pin_oe(pin_oe),
        .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));
    gpio_pin_model i_pin (.clk(clk), .rstn(rstn), .sw_data(sw_data), .sw_dir(sw_dir),
        .pin_o(pin_o), .pin_oe(pin_oe), .port_data_bit(port_data_bit),
        .pin_direction_bit(pin_direction_bit), .pin_level(pin_level));

    //======================================================================
    // Clock, checking and closing
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // Each read answer is matched against the oldest expected note.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk({pslverr, prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_FFFF_FFFF);
        end
    end
    // The whole run needs about 2000 cycles; this cuts a hang short.
    initial begin
        #200_000;
        error_cnt++;
        close_out();
    end

    //======================================================================
    // Bus and tick drivers, entered and left right after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) error_cnt++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h00_0000, v});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    // Ticks are single-cycle pulses spaced three cycles apart.
    task automatic tick(input int n);
        repeat (n) begin
            timer_tick <= 1'b1;
            @(posedge clk);
            timer_tick <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : tick

    //======================================================================
    // Main sequence
    initial begin
        {rstn, timer_tick, psel, penable, pwrite, sw_data, sw_dir} = 7'h00;
        ce = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        void'($urandom(32'h89C11AD5));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rd(A[i], 33'h0);
        rd(12'h014, 33'h1_0000_0000);
        // Normal mode wraps and raises overflow only on the step to zero.
        wr(A[1], 8'hFE);
        tick(1);
        rd(A[1], 33'hFF);
        rd(A[3], 33'h0);
        tick(1);
        rd(A[1], 33'h0);
        rd(A[3], 33'h1);
        chk({32'h0, overflow_flag}, 33'h1);
        wr(A[3], 8'h03);
        // A count write equal to compare hides that match; the next one toggles.
        wr(A[2], 8'h10);
        wr(A[0], 8'h10);
        wr(A[1], 8'h10);
        tick(1);
        rd(A[3], 33'h0);
        wr(A[1], 8'h0F);
        tick(2);
        rd(A[3], 33'h2);
        chk({32'h0, compare_match_flag}, 33'h1);
        rd(A[4], 33'h1);
        wr(A[0], 8'h00);
        wr(A[1], 8'h0F);
        tick(2);
        rd(A[4], 33'h1);
        wr(A[3], 8'h03);
        wr(A[0], 8'h90);
        rd(A[4], 33'h0);
        rd(A[3], 33'h0);
        rd(A[0], 33'h10);
        // Pin source over direction, output mode and waveform mode.
        for (int i = 0; i < 8; i++) begin
            wr(A[0], {3'b000, i[1], 2'b00, i[2], 1'b0});
            // Under override the port bit is one, so the low output state stands out.
            d = i[1] ? 1'b1 : 1'($urandom());
            sw_data <= d;
            sw_dir <= i[0];
            repeat (3) @(posedge clk);
            chk({32'h0, pin_level}, {32'h0, i[0] ? (i[1] ? 1'b0 : d) : 1'b1});
        end
        // Clear-on-match toggling, then a compare below the count.
        wr(A[0], 8'h12);
        wr(A[2], 8'h03);
        wr(A[1], 8'h00);
        wr(A[3], 8'h03);
        tick(4);
        rd(A[1], 33'h0);
        rd(A[3], 33'h2);
        rd(A[4], 33'h1);
        chk({32'h0, pin_level}, 33'h1);
        wr(A[1], 8'h05);
        wr(A[3], 8'h03);
        tick(251);
        rd(A[1], 33'h0);
        rd(A[3], 33'h1);
        // Fast PWM in both polarities; the new compare waits for the wrap.
        for (int p = 0; p < 2; p++) begin
            wr(A[0], p ? 8'h33 : 8'h23);
            // Each pass buffers a compare that the old active value never equals.
            cv = p ? 8'h40 : 8'h80;
            wr(A[2], cv);
            wr(A[3], 8'h03);
            wr(A[1], cv - 8'h01);
            tick(2);
            rd(A[3], 33'h0);
            wr(A[1], 8'hFE);
            tick(2);
            rd(A[1], 33'h0);
            rd(A[3], 33'h1);
            rd(A[4], {32'h0, p == 0});
            chk({32'h0, pin_level}, {32'h0, p == 0});
            wr(A[3], 8'h03);
            tick(int'(cv) + 1);
            rd(A[4], {32'h0, p == 1});
            rd(A[3], 33'h2);
        end
        // A reset in mid-run clears the output state; a low enable then freezes the count.
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(A[4], 33'h0);
        ce <= 1'b0;
        tick(2);
        ce <= 1'b1;
        rd(A[1], 33'h0);
        repeat (4) @(posedge clk);
        chk(33'(exp_q.size()), 33'h0);
        close_out();
    end
endmodule : tb_top
